// >>> hw/fdc_port_pkg.sv
`default_nettype none
// ---------------------------------------------------------------
// Shared constants and carriers for the floppy host port
// ---------------------------------------------------------------
package fdc_port_pkg;
   // APB register indices; byte address is four times the index
   localparam logic [7:0] IDX_FUNC_EN = 8'h00;     // function_enable_reg_one
   localparam logic [7:0] IDX_CHIP_CFG = 8'h21;    // chip_config_reg_one
   localparam logic [7:0] IDX_PORT_STATUS = 8'h30; // Read-only port status
   localparam int APB_AW = 12;                     // APB address width
   // Field positions
   localparam int FE_FDC_BIT = 3;                  // Function enable bit
   localparam int CFG_MODE_BIT = 2;                // Drive mode select bit
   localparam int DOR_DMA_BIT = 3;                 // DMA/IRQ gate bit
   // Reset values
   localparam logic [7:0] FUNC_EN_RST = 8'h00;
   localparam logic [7:0] CHIP_CFG_RST = 8'h00;
   localparam logic [7:0] DOR_RST = 8'h00;
   // Host register selects (low three address lines)
   localparam logic [2:0] SEL_STAT_A = 3'h0;       // Diagnostic status A
   localparam logic [2:0] SEL_STAT_B = 3'h1;       // Diagnostic status B
   localparam logic [2:0] SEL_DOR = 3'h2;          // digital_output_reg
   localparam logic [2:0] SEL_MAIN_STAT = 3'h4;    // Main status
   localparam logic [2:0] SEL_DATA = 3'h5;         // Command/data port
   // Commands and their parameter counts
   localparam logic [7:0] CMD_CONFIGURE = 8'h13;
   localparam logic [7:0] CMD_MODE = 8'h01;
   localparam logic [2:0] CONFIGURE_PARAMS = 3'h3;
   localparam logic [2:0] MODE_PARAMS = 3'h4;
   localparam logic [2:0] CONFIGURE_FIFO_IDX = 3'h1; // Param holding FIFO bit
   localparam logic [2:0] MODE_CTRL_IDX = 3'h0;      // Param holding mode bits
   localparam int CFG_FIFO_DIS_BIT = 5;            // 1 disables the FIFO
   localparam int MODE_FIFO_RD_BIT = 0;
   localparam int MODE_FIFO_WR_BIT = 1;
   localparam int MODE_BURST_DIS_BIT = 2;
   localparam int MODE_OPEN_DRAIN_BIT = 3;
   localparam int MODE_DENS_LSB = 4;
   // Density select programming
   localparam logic [1:0] DENS_AUTO = 2'h0;        // Follows data rate
   localparam logic [1:0] DENS_FORCE_HI = 2'h1;
   localparam logic [1:0] DENS_FORCE_LO = 2'h2;
   localparam logic [7:0] MAIN_STAT_READY = 8'h80; // Ready bit of main status
   localparam logic [7:0] MAIN_STAT_BUSY = 8'h10;  // Command in progress

   typedef struct packed {
      logic [6:0] addr_hi;                         // Upper address lines
      logic aen;
      logic rd_n;
      logic wr_n;
      logic [2:0] sel;                             // Register select
      logic [7:0] data;
      logic dack_n;
      logic tc;                                    // Raw terminal count pin
   } isa_in_s;

   typedef struct packed {
      logic [7:0] data;
      logic data_oe;
      logic irq;
      logic irq_oe;
      logic drq;
      logic drq_oe;
   } isa_out_s;

   typedef struct packed {
      logic fifo_en;
      logic fifo_rd_en;
      logic fifo_wr_en;
      logic burst_dis;
      logic open_drain;
      logic [1:0] dens_prog;
   } mode_s;
endpackage
`default_nettype wire

// >>> hw/fdc_strobe_edge.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// Falling edge detector for an active-low host strobe
// ---------------------------------------------------------------
module fdc_strobe_edge (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic strobe_n,
   output logic fell
);
   logic strobe_n_r; // Last sampled level; idle is high

   // Idle high so reset release fakes an edge only if the strobe is already low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strobe_n_r <= 1'b1;
      end else begin
         strobe_n_r <= strobe_n;
      end
   end

   assign fell = strobe_n_r & ~strobe_n;
endmodule // fdc_strobe_edge
`default_nettype wire

// >>> hw/fdc_byte_reg.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// Write-enabled register with a reset value
// ---------------------------------------------------------------
module fdc_byte_reg #(
   parameter int W = 8,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic we,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   // Holds until written
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= RESET_VAL;
      end else if (we) begin
         q <= d;
      end
   end
endmodule // fdc_byte_reg
`default_nettype wire

// >>> hw/fdc_host_port.sv
// Behaviour
// (R1) Controller active only when enable bit set
// (R2) FIFO disabled after power-on reset
// (R3) Disk outputs push-pull after reset
// (R4) Setup command switches data path to FIFO
// (R5) Mode command: FIFO enables, burst, drain, density
// (R6) Host decode, register select, IRQ and DMA
// (R7) Drive mode chosen by configuration bit
// (R8) High-polarity mode exposes legacy register set
// (R9) High-polarity: DMA bit gates IRQ, DRQ drivers
// (R10) High-polarity: TC, density active high
// (R11) Low-polarity: DMA bit ignored, always driven
// (R12) Low-polarity: TC, density active low
// (R13) Mode bit mapping is a parameter
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module fdc_host_port #(
   parameter logic [6:0] HOST_BASE = 7'h7e,  // Upper address match
   parameter logic HIGH_MODE_VAL = 1'b0      // Config bit value for high mode
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [fdc_port_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire fdc_port_pkg::isa_in_s isa_in,
   output fdc_port_pkg::isa_out_s isa_out,
   input wire logic core_irq_req,
   input wire logic core_drq_req,
   input wire logic rate_high,
   output logic tc_event,
   output logic density_select_out,
   output logic drive_open_drain,
   output logic fifo_rd_active,
   output logic fifo_wr_active,
   output logic burst_disable,
   output logic legacy_regs
);
   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------
   localparam logic [fdc_port_pkg::APB_AW-1:0] ADDR_FUNC_EN =
      {2'b00, fdc_port_pkg::IDX_FUNC_EN, 2'b00};
   localparam logic [fdc_port_pkg::APB_AW-1:0] ADDR_CHIP_CFG =
      {2'b00, fdc_port_pkg::IDX_CHIP_CFG, 2'b00};
   localparam logic [fdc_port_pkg::APB_AW-1:0] ADDR_STATUS =
      {2'b00, fdc_port_pkg::IDX_PORT_STATUS, 2'b00};

   logic [7:0] func_en_q;       // function_enable_reg_one
   logic [7:0] chip_cfg_q;      // chip_config_reg_one
   logic [7:0] dor_q;           // digital_output_reg
   fdc_port_pkg::mode_s mode_r; // Command-programmed path settings
   fdc_port_pkg::isa_out_s isa_out_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   // Function enable gates host decode, the IRQ/DRQ drivers and TC; declared early for the status word
   wire fdc_en = func_en_q[fdc_port_pkg::FE_FDC_BIT];                          // R1

   // Access phase answered one cycle after it opens
   wire apb_acc = psel & penable & ~pready_r;
   wire hit_fe = paddr == ADDR_FUNC_EN;
   wire hit_cfg = paddr == ADDR_CHIP_CFG;
   wire hit_st = paddr == ADDR_STATUS;
   wire apb_miss = ~(hit_fe | hit_cfg | hit_st);
   // Writes land on the answering edge only
   wire apb_wdone = psel & penable & pready_r & pwrite;
   wire fe_we = apb_wdone & hit_fe;
   wire cfg_we = apb_wdone & hit_cfg;

   // Status word shows the live state of the port
   wire [31:0] status_word = {24'h000000, 1'b0, legacy_regs,
                              mode_r.fifo_en, mode_r.open_drain,
                              dor_q[fdc_port_pkg::DOR_DMA_BIT],
                              isa_out_r.irq, isa_out_r.drq, fdc_en};

   // Read mux; unmapped reads give zero with an error
   wire [31:0] apb_rmux = hit_fe ? {24'h000000, func_en_q} :
                          hit_cfg ? {24'h000000, chip_cfg_q} :
                          hit_st ? status_word : 32'h00000000;

   fdc_byte_reg #(.W(8), .RESET_VAL(fdc_port_pkg::FUNC_EN_RST)) u_fe (
      .pclk(pclk),
      .presetn(presetn),
      .we(fe_we),
      .d(pwdata[7:0]),
      .q(func_en_q)
   );

   fdc_byte_reg #(.W(8), .RESET_VAL(fdc_port_pkg::CHIP_CFG_RST)) u_cfg (
      .pclk(pclk),
      .presetn(presetn),
      .we(cfg_we),
      .d(pwdata[7:0]),
      .q(chip_cfg_q)
   );

   // APB answer registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         prdata_r <= 32'h00000000;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= apb_acc;
         prdata_r <= (apb_acc & ~pwrite) ? apb_rmux : 32'h00000000;
         pslverr_r <= apb_acc & apb_miss;
      end
   end

   // ---------------------------------------------------------------
   // Mode and enable
   // ---------------------------------------------------------------
   wire high_mode = chip_cfg_q[fdc_port_pkg::CFG_MODE_BIT] == HIGH_MODE_VAL;   // R7 R13

   // ---------------------------------------------------------------
   // Host bus decode
   // ---------------------------------------------------------------
   // Chip select from upper lines and AEN, only while enabled
   wire host_cs = fdc_en & ~isa_in.aen & (isa_in.addr_hi == HOST_BASE); // R1 R6
   logic wr_fell;
   logic rd_fell;

   fdc_strobe_edge u_wr_edge (
      .pclk(pclk),
      .presetn(presetn),
      .strobe_n(isa_in.wr_n),
      .fell(wr_fell)
   );

   fdc_strobe_edge u_rd_edge (
      .pclk(pclk),
      .presetn(presetn),
      .strobe_n(isa_in.rd_n),
      .fell(rd_fell)
   );

   wire host_wr = host_cs & wr_fell;                                      // R6
   wire dor_we = host_wr & (isa_in.sel == fdc_port_pkg::SEL_DOR);
   wire data_wr = host_wr & (isa_in.sel == fdc_port_pkg::SEL_DATA);
   wire host_rd = host_cs & ~isa_in.rd_n;                                 // R6

   fdc_byte_reg #(.W(8), .RESET_VAL(fdc_port_pkg::DOR_RST)) u_dor (
      .pclk(pclk),
      .presetn(presetn),
      .we(dor_we),
      .d(isa_in.data),
      .q(dor_q)
   );

   // ---------------------------------------------------------------
   // Command capture
   // ---------------------------------------------------------------
   typedef enum logic {CMD_IDLE, CMD_PARAM} cmd_state_e;
   cmd_state_e cmd_st_r, cmd_st_nxt;
   logic [7:0] opcode_r;        // Command awaiting parameters
   logic [2:0] param_idx_r;     // Next parameter number
   logic [2:0] param_cnt_r;     // Parameters the command takes
   logic [7:0] opcode_nxt;
   logic [2:0] param_idx_nxt;
   logic [2:0] param_cnt_nxt;

   wire is_cfg_cmd = isa_in.data == fdc_port_pkg::CMD_CONFIGURE;
   wire is_mode_cmd = isa_in.data == fdc_port_pkg::CMD_MODE;
   wire in_param = cmd_st_r == CMD_PARAM;
   wire cfg_param_wr = data_wr & in_param & (opcode_r == fdc_port_pkg::CMD_CONFIGURE) &
                       (param_idx_r == fdc_port_pkg::CONFIGURE_FIFO_IDX);
   wire mode_param_wr = data_wr & in_param & (opcode_r == fdc_port_pkg::CMD_MODE) &
                        (param_idx_r == fdc_port_pkg::MODE_CTRL_IDX);

   // Unknown opcodes are dropped; this block only follows the setup and mode commands
   always_comb begin
      cmd_st_nxt = cmd_st_r;
      opcode_nxt = opcode_r;
      param_idx_nxt = param_idx_r;
      param_cnt_nxt = param_cnt_r;
      case (cmd_st_r)
         CMD_IDLE: begin
            if (data_wr & (is_cfg_cmd | is_mode_cmd)) begin
               cmd_st_nxt = CMD_PARAM;
               opcode_nxt = isa_in.data;
               param_idx_nxt = 3'h0;
               param_cnt_nxt = is_cfg_cmd ? fdc_port_pkg::CONFIGURE_PARAMS :
                                            fdc_port_pkg::MODE_PARAMS;
            end
         end
         CMD_PARAM: begin
            if (data_wr) begin
               param_idx_nxt = param_idx_r + 3'h1;
               if (param_idx_r + 3'h1 == param_cnt_r) begin
                  cmd_st_nxt = CMD_IDLE;
               end
            end
         end
         default: begin
            cmd_st_nxt = CMD_IDLE;
         end
      endcase
   end

   // Sequencer state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_st_r <= CMD_IDLE;
         opcode_r <= 8'h00;
         param_idx_r <= 3'h0;
         param_cnt_r <= 3'h0;
      end else begin
         cmd_st_r <= cmd_st_nxt;
         opcode_r <= opcode_nxt;
         param_idx_r <= param_idx_nxt;
         param_cnt_r <= param_cnt_nxt;
      end
   end

   // Path settings; FIFO off and push-pull until software asks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r.fifo_en <= 1'b0;                                          // R2
         mode_r.fifo_rd_en <= 1'b1;
         mode_r.fifo_wr_en <= 1'b1;
         mode_r.burst_dis <= 1'b0;
         mode_r.open_drain <= 1'b0;                                       // R3
         mode_r.dens_prog <= fdc_port_pkg::DENS_AUTO;
      end else begin
         if (cfg_param_wr) begin
            mode_r.fifo_en <= ~isa_in.data[fdc_port_pkg::CFG_FIFO_DIS_BIT]; // R4
         end
         if (mode_param_wr) begin
            mode_r.fifo_rd_en <= isa_in.data[fdc_port_pkg::MODE_FIFO_RD_BIT];   // R5
            mode_r.fifo_wr_en <= isa_in.data[fdc_port_pkg::MODE_FIFO_WR_BIT];   // R5
            mode_r.burst_dis <= isa_in.data[fdc_port_pkg::MODE_BURST_DIS_BIT];  // R5
            mode_r.open_drain <= isa_in.data[fdc_port_pkg::MODE_OPEN_DRAIN_BIT]; // R5
            mode_r.dens_prog <= isa_in.data[fdc_port_pkg::MODE_DENS_LSB +: 2];  // R5
         end
      end
   end

   // ---------------------------------------------------------------
   // Host read data and pin drivers
   // ---------------------------------------------------------------
   // Diagnostic registers exist only in the low-polarity set
   wire [7:0] stat_a = {isa_out_r.irq, 6'h00, isa_out_r.drq};
   wire [7:0] stat_b = {6'h00, mode_r.fifo_en, density_select_out};
   wire [7:0] main_stat = fdc_port_pkg::MAIN_STAT_READY |
                          (in_param ? fdc_port_pkg::MAIN_STAT_BUSY : 8'h00);
   wire [7:0] host_rmux =
      (isa_in.sel == fdc_port_pkg::SEL_STAT_A && !high_mode) ? stat_a :   // R8
      (isa_in.sel == fdc_port_pkg::SEL_STAT_B && !high_mode) ? stat_b :   // R8
      (isa_in.sel == fdc_port_pkg::SEL_DOR) ? dor_q :
      (isa_in.sel == fdc_port_pkg::SEL_MAIN_STAT) ? main_stat : 8'h00;

   // Gate: high mode obeys the DMA bit, low mode always drives
   wire req_drive = fdc_en & (~high_mode | dor_q[fdc_port_pkg::DOR_DMA_BIT]); // R9 R11
   // Terminal count counts only during an acknowledged DMA cycle
   wire tc_level = high_mode ? isa_in.tc : ~isa_in.tc;                     // R10 R12
   // Logical density: high means the high-rate setting
   wire dens_logic = (mode_r.dens_prog == fdc_port_pkg::DENS_FORCE_HI) ? 1'b1 :
                     (mode_r.dens_prog == fdc_port_pkg::DENS_FORCE_LO) ? 1'b0 :
                     rate_high;
   wire dens_pin = high_mode ? dens_logic : ~dens_logic;                  // R10 R12

   // Pin registers; every output leaves from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         isa_out_r <= '0;
         tc_event <= 1'b0;
         density_select_out <= 1'b0;
         drive_open_drain <= 1'b0;                                        // R3
         fifo_rd_active <= 1'b0;                                          // R2
         fifo_wr_active <= 1'b0;                                          // R2
         burst_disable <= 1'b0;
         legacy_regs <= 1'b0;
      end else begin
         isa_out_r.data <= host_rd ? host_rmux : 8'h00;
         isa_out_r.data_oe <= host_rd;                                    // R6
         isa_out_r.irq <= core_irq_req;
         isa_out_r.irq_oe <= req_drive;                                   // R9 R11
         isa_out_r.drq <= core_drq_req;
         isa_out_r.drq_oe <= req_drive;                                   // R9 R11
         tc_event <= fdc_en & ~isa_in.dack_n & tc_level;                  // R10 R12
         density_select_out <= dens_pin;                                  // R10 R12
         drive_open_drain <= mode_r.open_drain;
         fifo_rd_active <= mode_r.fifo_en & mode_r.fifo_rd_en;            // R4 R5
         fifo_wr_active <= mode_r.fifo_en & mode_r.fifo_wr_en;            // R4 R5
         burst_disable <= mode_r.burst_dis;
         legacy_regs <= high_mode;                                        // R8
      end
   end

   assign isa_out = isa_out_r;
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_off_quiet;
      !fdc_en |=> !isa_out_r.irq_oe && !isa_out_r.drq_oe && !isa_out_r.data_oe;
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("outputs driven while off"); // R1

   property p_fifo_stays_off;
      !mode_r.fifo_en && !cfg_param_wr |=> !mode_r.fifo_en;
   endproperty
   a_fifo_stays_off: assert property (p_fifo_stays_off) else $error("fifo enabled alone"); // R2

   property p_push_pull_held;
      !mode_r.open_drain && !mode_param_wr |=> ##1 !drive_open_drain;
   endproperty
   a_push_pull_held: assert property (p_push_pull_held) else $error("open-drain unasked"); // R3

   sequence s_cfg_cmd;
      data_wr && is_cfg_cmd && !in_param;
   endsequence
   sequence s_fifo_on;
      cfg_param_wr && !isa_in.data[fdc_port_pkg::CFG_FIFO_DIS_BIT];
   endsequence
   property p_fifo_setup;
      s_fifo_on |=> mode_r.fifo_en ##1 (fifo_rd_active == mode_r.fifo_rd_en);
   endproperty
   a_fifo_setup: assert property (p_fifo_setup) else $error("fifo setup ignored"); // R4

   property p_cfg_starts;
      s_cfg_cmd |=> in_param && param_cnt_r == fdc_port_pkg::CONFIGURE_PARAMS;
   endproperty
   a_cfg_starts: assert property (p_cfg_starts) else $error("setup not accepted"); // R4

   property p_mode_fields;
      mode_param_wr |=> ##1
         drive_open_drain == $past(isa_in.data[fdc_port_pkg::MODE_OPEN_DRAIN_BIT], 2) &&
         burst_disable == $past(isa_in.data[fdc_port_pkg::MODE_BURST_DIS_BIT], 2);
   endproperty
   a_mode_fields: assert property (p_mode_fields) else $error("mode fields lost"); // R5

   property p_host_read;
      host_rd |=> isa_out_r.data_oe;
   endproperty
   a_host_read: assert property (p_host_read) else $error("read not driven"); // R6

   property p_dor_write;
      dor_we |=> dor_q == $past(isa_in.data);
   endproperty
   a_dor_write: assert property (p_dor_write) else $error("dor write lost"); // R6

   property p_legacy;
      $changed(chip_cfg_q) |=> legacy_regs == high_mode;
   endproperty
   a_legacy: assert property (p_legacy) else $error("mode flag stale"); // R7 R8 R13

   property p_high_gate;
      fdc_en && high_mode && !dor_q[fdc_port_pkg::DOR_DMA_BIT]
         |=> !isa_out_r.irq_oe && !isa_out_r.drq_oe;
   endproperty
   a_high_gate: assert property (p_high_gate) else $error("gate not honoured"); // R9

   property p_low_drive;
      fdc_en && !high_mode |=> isa_out_r.irq_oe && isa_out_r.drq_oe;
   endproperty
   a_low_drive: assert property (p_low_drive) else $error("low mode undriven"); // R11

   property p_high_pol;
      high_mode && mode_r.dens_prog == fdc_port_pkg::DENS_AUTO
         |=> density_select_out == $past(rate_high);
   endproperty
   a_high_pol: assert property (p_high_pol) else $error("density polarity high"); // R10

   property p_low_pol;
      fdc_en && !high_mode && !isa_in.dack_n
         |=> tc_event == !$past(isa_in.tc);
   endproperty
   a_low_pol: assert property (p_low_pol) else $error("tc polarity low"); // R12
endmodule // fdc_host_port
`default_nettype wire

// >>> verification/isa_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Host processor and DMA side of the port
// ----------------------------------------
module isa_host_model #(
   parameter logic [6:0] BASE = 7'h7e // Upper address of the port
) (
   input wire logic pclk,
   input wire fdc_port_pkg::isa_out_s isa_out,
   output fdc_port_pkg::isa_in_s isa_in
);
   logic [7:0] last_d; // Last byte the host drove
   // Idle bus: strobes high, DMA acknowledge off
   initial begin
      isa_in = '0;
      isa_in.addr_hi = BASE;
      isa_in.rd_n = 1'b1;
      isa_in.wr_n = 1'b1;
      isa_in.dack_n = 1'b1;
      last_d = 8'h00;
   end
   // Strobe two cycles low, two high; released data shows inverse
   task automatic wr(input logic [2:0] s, input logic [7:0] d, input logic a);
      @(posedge pclk);
      isa_in.sel <= s;
      isa_in.data <= d;
      isa_in.aen <= a;
      isa_in.wr_n <= 1'b0;
      last_d = d;
      repeat (2) @(posedge pclk);
      isa_in.wr_n <= 1'b1;
      isa_in.aen <= 1'b0;
      isa_in.data <= ~last_d;
      repeat (2) @(posedge pclk);
   endtask
   // Read data taken late in the strobe; an undriven bus floats high on its pull-ups
   task automatic rd(input logic [2:0] s, output logic [7:0] d);
      @(posedge pclk);
      isa_in.sel <= s;
      isa_in.rd_n <= 1'b0;
      repeat (3) @(posedge pclk);
      d = isa_out.data_oe ? isa_out.data : 8'hff;
      isa_in.rd_n <= 1'b1;
      repeat (2) @(posedge pclk);
   endtask
   // DMA acknowledge and terminal count levels
   task automatic dma(input logic dk, input logic t);
      @(posedge pclk);
      isa_in.dack_n <= dk;
      isa_in.tc <= t;
   endtask
endmodule // isa_host_model
`default_nettype wire

// >>> verification/floppy_host_port_mode_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module floppy_host_port_mode_control_tb;
   typedef struct packed {logic err; logic [31:0] d;} note_s;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [fdc_port_pkg::APB_AW-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic irq_req, drq_req, rate_high, tc_ev, dens, odr, frd, fwr, bdis, leg, lg;
   fdc_port_pkg::isa_in_s isa_in;
   fdc_port_pkg::isa_out_s isa_out;
   note_s notes[$]; // Expected APB answers, oldest first
   note_s cur;
   int mismatches, num_checks, cycles;
   logic [7:0] hd, m;
   fdc_host_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .isa_in(isa_in), .isa_out(isa_out), .core_irq_req(irq_req),
      .core_drq_req(drq_req), .rate_high(rate_high), .tc_event(tc_ev),
      .density_select_out(dens), .drive_open_drain(odr), .fifo_rd_active(frd),
      .fifo_wr_active(fwr), .burst_disable(bdis), .legacy_regs(leg));
   isa_host_model HOST (.pclk(pclk), .isa_out(isa_out), .isa_in(isa_in));
   // ----------------------------------------
   // Checking and closing
   // ----------------------------------------
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Answer watcher and hang guard
   always @(posedge pclk) begin
      cycles++;
      if (presetn && pready) begin
         cur = notes.pop_front();
         chk({pslverr, prdata}, cur);
      end
      if (cycles == 20000) begin
         mismatches++;
         conclude();
      end
   end
   // APB master: waits for pready; only the bench timeout ends a hang
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                      input logic e, input logic [7:0] x);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'($urandom), d}; // Upper bits must be ignored
      notes.push_back({e, 24'h0, w ? 8'h00 : x});
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic settle;
      repeat (3) @(posedge pclk);
      #1;
   endtask
   // Setup command; dis set turns the FIFO back off
   task automatic setup_cmd(input logic dis);
      HOST.wr(fdc_port_pkg::SEL_DATA, fdc_port_pkg::CMD_CONFIGURE, 1'b0);
      HOST.wr(fdc_port_pkg::SEL_DATA, 8'h00, 1'b0);
      HOST.wr(fdc_port_pkg::SEL_DATA, {2'h0, dis, 5'h00}, 1'b0);
      HOST.wr(fdc_port_pkg::SEL_DATA, 8'h00, 1'b0);
      settle();
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      pclk = 0;
      forever #10 pclk = ~pclk;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {irq_req, drq_req, rate_high, mismatches, num_checks, cycles} = '0;
      void'($urandom(39782));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      settle();
      chk({frd, fwr, odr}, 3'h0);
      apb(0, 12'h000, 8'h00, 0, fdc_port_pkg::FUNC_EN_RST);
      apb(0, 12'h084, 8'h00, 0, fdc_port_pkg::CHIP_CFG_RST);
      apb(1, 12'h010, 8'h5a, 1, 8'h00);
      apb(0, 12'h010, 8'h00, 1, 8'h00);
      setup_cmd(0);
      HOST.rd(fdc_port_pkg::SEL_MAIN_STAT, hd);
      chk({frd, hd}, 9'h0ff);
      apb(1, 12'h000, 8'h08, 0, 8'h00);
      apb(0, 12'h000, 8'h00, 0, 8'h08);
      HOST.wr(fdc_port_pkg::SEL_DATA, fdc_port_pkg::CMD_CONFIGURE, 1'b0);
      HOST.rd(fdc_port_pkg::SEL_MAIN_STAT, hd);
      chk(hd, 8'h90);
      // Finish the pending command with the FIFO kept off, so setup starts clean
      repeat (3) HOST.wr(fdc_port_pkg::SEL_DATA, 8'h20, 1'b0);
      chk({frd, fwr}, 2'h0);
      setup_cmd(0);
      chk({frd, fwr}, 2'h3);
      for (int md = 0; md < 2; md++) begin
         apb(1, 12'h084, md ? 8'h04 : 8'h00, 0, 8'h00);
         HOST.wr(fdc_port_pkg::SEL_DOR, 8'h00, 1'b0);
         HOST.wr(fdc_port_pkg::SEL_DOR, 8'h08, 1'b1); // Ignored: DMA cycle
         irq_req <= 1'($urandom);
         drq_req <= 1'($urandom);
         settle();
         chk({leg, isa_out.irq_oe, isa_out.drq_oe}, {md == 0, md == 1, md == 1});
         HOST.wr(fdc_port_pkg::SEL_DOR, 8'h08, 1'b0);
         HOST.rd(fdc_port_pkg::SEL_DOR, hd);
         settle();
         chk({hd, isa_out.irq_oe, isa_out.drq_oe}, {8'h08, 2'h3});
         chk({isa_out.irq, isa_out.drq}, {irq_req, drq_req});
         for (int i = 0; i < 3; i++) begin
            m = 8'($urandom) & 8'h0f;
            rate_high <= 1'($urandom);
            HOST.wr(fdc_port_pkg::SEL_DATA, fdc_port_pkg::CMD_MODE, 1'b0);
            HOST.wr(fdc_port_pkg::SEL_DATA, {2'h0, 2'(i), m[3:0]}, 1'b0);
            repeat (3) HOST.wr(fdc_port_pkg::SEL_DATA, 8'($urandom), 1'b0);
            settle();
            lg = (i == 0) ? rate_high : (i == 1);
            chk({odr, bdis, fwr, frd}, m[3:0]);
            chk(dens, lg ^ md);
         end
         // Last density was forced low: pin reads high in low-polarity mode
         HOST.rd(fdc_port_pkg::SEL_STAT_B, hd);
         chk(hd, md ? 8'h03 : 8'h00);
         HOST.dma(1'b0, md == 0);
         settle();
         chk(tc_ev, 1'b1);
         HOST.dma(1'b0, md == 1);
         settle();
         chk(tc_ev, 1'b0);
         HOST.dma(1'b1, md == 0);
      end
      setup_cmd(1);
      chk({frd, fwr}, 2'h0);
      apb(0, 12'h0c0, 8'h00, 0, {3'h0, m[3], 1'b1, irq_req, drq_req, 1'b1});
      conclude();
   end
endmodule // floppy_host_port_mode_control_tb
`default_nettype wire
